// ---- design/spsc_defines.svh ----
// register map, field positions, reset values and timing constants
`ifndef SPSC_DEFINES_SVH
`define SPSC_DEFINES_SVH

// register indices; byte address is four times the index
`define SPSC_IDX_STATUS 8'h20
`define SPSC_IDX_DATA 8'h21
`define SPSC_IDX_CTRL1 8'h23
`define SPSC_IDX_CTRL2 8'h24
`define SPSC_ADDR_STATUS 8'h80
`define SPSC_ADDR_DATA 8'h84
`define SPSC_ADDR_CTRL1 8'h8C
`define SPSC_ADDR_CTRL2 8'h90

// reset values
`define SPSC_RST_STATUS 8'hC0
`define SPSC_RST_CTRL1 8'h00
`define SPSC_RST_CTRL2 8'h00

// control one fields
`define SPSC_C1_RX9 7
`define SPSC_C1_TX9 6
`define SPSC_C1_LPSTOP 5
`define SPSC_C1_WLEN 4
`define SPSC_C1_WAKE 3
`define SPSC_C1_PEN 2
`define SPSC_C1_PODD 1
`define SPSC_C1_PIE 0

// control two fields
`define SPSC_C2_TIE 7
`define SPSC_C2_TX_DONE_IRQ_EN 6
`define SPSC_C2_RIE 5
`define SPSC_C2_LINE_QUIET_IRQ_EN 4
`define SPSC_C2_TE 3
`define SPSC_C2_RE 2
`define SPSC_C2_MUTE 1
`define SPSC_C2_BRK 0

// timing: bit rate and oversampling
`define SPSC_CLK_HZ 50000000
`define SPSC_BAUD 115200
`define SPSC_OVERSAMPLE 16
`define SPSC_TICK_DIV (`SPSC_CLK_HZ / (`SPSC_BAUD * `SPSC_OVERSAMPLE))

// axi responses
`define SPSC_RESP_OKAY 2'b00
`define SPSC_RESP_SLVERR 2'b10

`endif

// ---- design/spsc_pkg.sv ----
// types shared by the serial port status and control block
package spsc_pkg;
    typedef enum logic [1:0] {
        SPSC_TX_IDLE = 2'b01,
        SPSC_TX_SHIFT = 2'b10
    } spsc_tx_state_t;

    typedef enum logic [3:0] {
        SPSC_RX_IDLE = 4'b0001,
        SPSC_RX_START = 4'b0010,
        SPSC_RX_DATA = 4'b0100,
        SPSC_RX_STOP = 4'b1000
    } spsc_rx_state_t;
endpackage

// ---- design/spsc_top.sv ----
// serial port with status/control registers on an axi4-lite slave
// What this block does
// - set tx empty on holding-to-shifter move, irq
// - clear tx flags: status access, data write
// - no shifter load while tx empty set
// - set tx done after data/preamble/break frame
// - clear rx flags: status access, data read
// - quiet flag once per received word
// - overrun keeps holding register, shifter overwritten
// - noise flag set without own interrupt
// - framing error flag; overrun takes precedence
// - parity error flag with its interrupt enable
// - ninth bit received and transmitted
// - low-power stop halts ticks after frame
// - word length eight or nine bits
// - wake method: quiet line or address mark
// - parity replaces msb, applies next frame
// - even or odd parity, next frame
// - interrupt when any enabled flag set
// - transmit pin owned until both enables off
// - enable pulse during frame sends preamble
// - receiver enable starts start-bit search
// - mute bit, hardware clears on wake
// - break bit sends breaks; pulse sends one
// - muted receiver sets no flags, no irq
// - address mark wakes and receives word
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "spsc_defines.svh"

module spsc_top
    import spsc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // axi4-lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // serial pins
    input wire logic rxd,
    output logic txd,
    output logic txd_oe,
    // interrupt request
    output logic irq
);
    localparam logic [15:0] TICK_DIV = 16'(`SPSC_TICK_DIV);
    localparam logic [7:0] RST_STATUS = `SPSC_RST_STATUS;

    // registers
    logic [7:0] ctrl_one;
    logic [7:0] ctrl_two;
    logic tx_empty_flag, tx_done_flag, rx_full_flag, quiet_flag;
    logic overrun_flag, noise_flag, framing_error_flag, parity_error_flag;
    logic [7:0] tx_holding_reg, rx_holding_reg;
    logic rx_ninth_bit;
    logic status_seen;

    // axi holding state
    logic aw_held, w_held;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic wr_lane0;

    // pin sync and ticks
    logic rxd_meta, rxd_s;
    logic [15:0] tick_cnt;
    logic tick;

    // transmitter
    spsc_tx_state_t tx_state;
    logic [10:0] tx_frame;
    logic [3:0] tx_bits;
    logic [3:0] tx_sub;
    logic te_prev, brk_prev, pre_pend, brk_pend;

    // receiver
    spsc_rx_state_t rx_state;
    logic [3:0] rx_sub;
    logic [3:0] rx_bits;
    logic [8:0] rx_shift;
    logic [2:0] rx_samp;
    logic rx_noise;
    logic rx_m, rx_pen, rx_podd;
    logic [7:0] idle_cnt;
    logic quiet_armed;

    // control fields
    wire wlen9 = ctrl_one[`SPSC_C1_WLEN];
    wire lp_stop = ctrl_one[`SPSC_C1_LPSTOP];
    wire pen = ctrl_one[`SPSC_C1_PEN];
    wire podd = ctrl_one[`SPSC_C1_PODD];
    wire tx_enable = ctrl_two[`SPSC_C2_TE];
    wire rx_enable = ctrl_two[`SPSC_C2_RE];
    wire rx_mute = ctrl_two[`SPSC_C2_MUTE];
    wire send_brk = ctrl_two[`SPSC_C2_BRK];

    // bus decode
    wire wr_go = aw_held && w_held && !s_axi_bvalid;
    wire wr_en = wr_go && wr_lane0;
    wire wr_ctrl1 = wr_en && (wr_addr == `SPSC_ADDR_CTRL1);
    wire wr_ctrl2 = wr_en && (wr_addr == `SPSC_ADDR_CTRL2);
    wire wr_dat = wr_en && (wr_addr == `SPSC_ADDR_DATA);
    wire wr_hit = (wr_addr == `SPSC_ADDR_STATUS) ||
                  (wr_addr == `SPSC_ADDR_DATA) ||
                  (wr_addr == `SPSC_ADDR_CTRL1) ||
                  (wr_addr == `SPSC_ADDR_CTRL2);
    wire rd_go = s_axi_arvalid && s_axi_arready;
    wire rd_stat = rd_go && (s_axi_araddr == `SPSC_ADDR_STATUS);
    wire rd_dat = rd_go && (s_axi_araddr == `SPSC_ADDR_DATA);
    wire rd_c1 = (s_axi_araddr == `SPSC_ADDR_CTRL1);
    wire rd_c2 = (s_axi_araddr == `SPSC_ADDR_CTRL2);
    wire rd_hit = (s_axi_araddr == `SPSC_ADDR_STATUS) ||
                  (s_axi_araddr == `SPSC_ADDR_DATA) || rd_c1 || rd_c2;
    wire [7:0] status_val = {tx_empty_flag, tx_done_flag, rx_full_flag,
                             quiet_flag, overrun_flag, noise_flag,
                             framing_error_flag, parity_error_flag};
    wire [7:0] rd_byte = (s_axi_araddr == `SPSC_ADDR_STATUS) ? status_val :
                         (s_axi_araddr == `SPSC_ADDR_DATA) ? rx_holding_reg :
                         rd_c1 ? {rx_ninth_bit, ctrl_one[6:0]} :
                         rd_c2 ? ctrl_two : 8'h00;
    wire tx_clr = status_seen && wr_dat;
    wire rx_clr = status_seen && rd_dat;

    // ticks stop only once both shifters are idle
    wire halted = lp_stop && (tx_state == SPSC_TX_IDLE) &&
                  (rx_state == SPSC_RX_IDLE);

    // transmit frame build; parity taken from live bits at load time
    wire [7:0] hd = tx_holding_reg;
    // parity over seven or eight low bits
    wire par8 = (^hd[7:0]) ^ podd;
    wire par7 = (^hd[6:0]) ^ podd;
    wire [7:0] hd_out = (pen && !wlen9) ? {par7, hd[6:0]} : hd;
    wire nine_out = pen ? par8 : ctrl_one[`SPSC_C1_TX9];
    wire [10:0] data_frame = wlen9 ? {1'b1, nine_out, hd_out, 1'b0} :
                                     {2'b11, hd_out, 1'b0};
    wire [3:0] frame_len = wlen9 ? 4'd11 : 4'd10;
    // start on a tick so the start bit is a whole bit long
    wire tx_can_start = (tx_state == SPSC_TX_IDLE) && tx_enable &&
                        !lp_stop && tick;
    wire want_brk = send_brk || brk_pend;
    // holding moves only when software has refilled it
    wire tx_load = tx_can_start && !want_brk && !pre_pend && !tx_empty_flag;
    wire tx_end = (tx_state == SPSC_TX_SHIFT) && tick && (tx_sub == 4'hF) &&
                  (tx_bits == 4'd1);

    // receiver decode
    wire maj = (rx_samp[0] & rx_samp[1]) | (rx_samp[1] & rx_samp[2]) |
               (rx_samp[0] & rx_samp[2]);
    wire samp_noisy = !(&rx_samp) && (|rx_samp);
    wire rx_bit_end = tick && (rx_sub == 4'hF);
    wire rx_done = (rx_state == SPSC_RX_STOP) && tick && (rx_sub == 4'hA);
    wire [8:0] rx_word = rx_m ? rx_shift : {1'b0, rx_shift[8:1]};
    wire rx_msb = rx_m ? rx_word[8] : rx_word[7];
    wire par_bad = rx_pen &&
                   (((rx_m ? ^rx_word[8:0] : ^rx_word[7:0])) != rx_podd);
    wire addr_wake = rx_done && rx_mute && ctrl_one[`SPSC_C1_WAKE] && rx_msb;
    wire rx_accept = rx_done && (!rx_mute || addr_wake);
    wire rx_store = rx_accept && !rx_full_flag;
    wire rx_over = rx_accept && rx_full_flag;
    wire [7:0] idle_len = wlen9 ? 8'd176 : 8'd160;
    wire line_idle = tick && (rx_state == SPSC_RX_IDLE) && rx_enable &&
                     (idle_cnt == idle_len - 8'd1);
    // quiet-line wake, no quiet flag then
    wire idle_wake = line_idle && rx_mute && !ctrl_one[`SPSC_C1_WAKE];
    // one quiet flag per received word
    wire quiet_set = line_idle && !rx_mute && quiet_armed;

    // pin synchroniser
    always_ff @(posedge clk) begin
        if (srst) begin
            rxd_meta <= 1'b1;
            rxd_s <= 1'b1;
        end else begin
            rxd_meta <= rxd;
            rxd_s <= rxd_meta;
        end
    end

    // oversampling tick
    always_ff @(posedge clk) begin
        if (srst || halted || tick_cnt == TICK_DIV - 16'd1) begin
            tick_cnt <= 16'h0000;
        end else begin
            tick_cnt <= tick_cnt + 16'd1;
        end
        tick <= !srst && !halted && (tick_cnt == TICK_DIV - 16'd1);
    end

    // axi write channel: address and data taken in either order
    always_ff @(posedge clk) begin
        if (srst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SPSC_RESP_OKAY;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
            wr_lane0 <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                s_axi_awready <= 1'b0;
                wr_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                s_axi_wready <= 1'b0;
                wr_data <= s_axi_wdata[7:0];
                wr_lane0 <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `SPSC_RESP_OKAY : `SPSC_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // axi read channel
    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SPSC_RESP_OKAY;
        end else if (rd_go) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= rd_hit ? `SPSC_RESP_OKAY : `SPSC_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // control registers and data port
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_one <= `SPSC_RST_CTRL1;
            ctrl_two <= `SPSC_RST_CTRL2;
            tx_holding_reg <= 8'h00;
            status_seen <= 1'b0;
        end else begin
            if (wr_ctrl1) begin
                ctrl_one <= {1'b0, wr_data[6:0]};
            end
            // software write to mute wins over a wake in the same cycle
            if (wr_ctrl2) begin
                ctrl_two <= wr_data;
            end else if (addr_wake || idle_wake) begin
                ctrl_two[`SPSC_C2_MUTE] <= 1'b0;
            end
            if (wr_dat) begin
                tx_holding_reg <= wr_data;
            end
            // remember status access until a data access
            if (rd_stat || (wr_en && wr_addr == `SPSC_ADDR_STATUS)) begin
                status_seen <= 1'b1;
            end else if (rd_dat || wr_dat) begin
                status_seen <= 1'b0;
            end
        end
    end

    // transmit flags; a set in the clearing cycle wins
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_empty_flag <= RST_STATUS[7];
            tx_done_flag <= RST_STATUS[6];
        end else begin
            // empty on load, cleared by sequence
            if (tx_load) begin
                tx_empty_flag <= 1'b1;
            end else if (tx_clr) begin
                tx_empty_flag <= 1'b0;
            end
            if (tx_end) begin
                tx_done_flag <= 1'b1;
            end else if (tx_clr) begin
                tx_done_flag <= 1'b0;
            end
        end
    end

    // transmitter shifter
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_state <= SPSC_TX_IDLE;
            tx_frame <= 11'h7FF;
            tx_bits <= 4'd0;
            tx_sub <= 4'h0;
            txd <= 1'b1;
            te_prev <= 1'b0;
            brk_prev <= 1'b0;
            pre_pend <= 1'b0;
            brk_pend <= 1'b0;
        end else begin
            te_prev <= tx_enable;
            brk_prev <= send_brk;
            // enable pulse while busy queues a preamble
            if (tx_state == SPSC_TX_SHIFT && tx_enable && !te_prev) begin
                pre_pend <= 1'b1;
            end
            // break bit pulse queues one break
            if (tx_state == SPSC_TX_SHIFT && brk_prev && !send_brk) begin
                brk_pend <= 1'b1;
            end
            unique case (tx_state)
                SPSC_TX_IDLE: begin
                    txd <= 1'b1;
                    tx_sub <= 4'h0;
                    tx_bits <= frame_len;
                    if (tx_can_start && want_brk) begin
                        tx_frame <= 11'h000;
                        brk_pend <= 1'b0;
                        tx_state <= SPSC_TX_SHIFT;
                    end else if (tx_can_start && pre_pend) begin
                        tx_frame <= 11'h7FF;
                        pre_pend <= 1'b0;
                        tx_state <= SPSC_TX_SHIFT;
                    // frame of ten or eleven bits
                    end else if (tx_load) begin
                        tx_frame <= data_frame;
                        tx_state <= SPSC_TX_SHIFT;
                    end
                end
                SPSC_TX_SHIFT: begin
                    txd <= tx_frame[0];
                    if (tick) begin
                        tx_sub <= tx_sub + 4'h1;
                        if (tx_sub == 4'hF) begin
                            tx_frame <= {1'b1, tx_frame[10:1]};
                            tx_bits <= tx_bits - 4'd1;
                            if (tx_bits == 4'd1) begin
                                tx_state <= SPSC_TX_IDLE;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // pin kept until both enables are off
    always_ff @(posedge clk) begin
        if (srst) begin
            txd_oe <= 1'b0;
        end else begin
            txd_oe <= tx_enable || (txd_oe && rx_enable);
        end
    end

    // receiver shifter
    always_ff @(posedge clk) begin
        if (srst) begin
            rx_state <= SPSC_RX_IDLE;
            rx_sub <= 4'h0;
            rx_bits <= 4'd0;
            rx_shift <= 9'h000;
            rx_samp <= 3'b111;
            rx_noise <= 1'b0;
            rx_m <= 1'b0;
            rx_pen <= 1'b0;
            rx_podd <= 1'b0;
        end else begin
            if (tick && rx_sub >= 4'h7 && rx_sub <= 4'h9) begin
                rx_samp <= {rx_samp[1:0], rxd_s};
            end
            if (tick) begin
                rx_sub <= rx_sub + 4'h1;
            end
            unique case (rx_state)
                SPSC_RX_IDLE: begin
                    rx_sub <= 4'h0;
                    rx_noise <= 1'b0;
                    // search for start bit when enabled
                    if (rx_enable && !lp_stop && !rxd_s) begin
                        rx_state <= SPSC_RX_START;
                        rx_m <= wlen9;
                        rx_pen <= pen;
                        rx_podd <= podd;
                    end
                end
                SPSC_RX_START: begin
                    if (rx_bit_end) begin
                        rx_bits <= 4'd0;
                        rx_noise <= samp_noisy;
                        rx_state <= maj ? SPSC_RX_IDLE : SPSC_RX_DATA;
                    end
                end
                SPSC_RX_DATA: begin
                    if (rx_bit_end) begin
                        // nine bits shift fully when selected
                        rx_shift <= {maj, rx_shift[8:1]};
                        rx_noise <= rx_noise | samp_noisy;
                        rx_bits <= rx_bits + 4'd1;
                        if (rx_bits == (rx_m ? 4'd8 : 4'd7)) begin
                            rx_state <= SPSC_RX_STOP;
                        end
                    end
                end
                SPSC_RX_STOP: begin
                    // end mid stop bit to catch a following start
                    if (rx_done) begin
                        rx_state <= SPSC_RX_IDLE;
                    end
                end
            endcase
            if (!rx_enable) begin
                rx_state <= SPSC_RX_IDLE;
            end
        end
    end

    // quiet-line detection
    always_ff @(posedge clk) begin
        if (srst || rxd_s == 1'b0 || rx_state != SPSC_RX_IDLE) begin
            idle_cnt <= 8'h00;
        end else if (tick && idle_cnt != idle_len) begin
            idle_cnt <= idle_cnt + 8'd1;
        end
    end

    // receive flags and holding register; sets win over clears
    always_ff @(posedge clk) begin
        if (srst) begin
            rx_full_flag <= 1'b0;
            quiet_flag <= 1'b0;
            overrun_flag <= 1'b0;
            noise_flag <= 1'b0;
            framing_error_flag <= 1'b0;
            parity_error_flag <= 1'b0;
            rx_holding_reg <= 8'h00;
            rx_ninth_bit <= 1'b0;
            quiet_armed <= 1'b0;
        end else begin
            // status access then data read clears
            if (rx_clr) begin
                rx_full_flag <= 1'b0;
                quiet_flag <= 1'b0;
                overrun_flag <= 1'b0;
                noise_flag <= 1'b0;
                framing_error_flag <= 1'b0;
            end
            // parity clears on a data read or write
            if (rx_clr || tx_clr) begin
                parity_error_flag <= 1'b0;
            end
            if (rx_over) begin
                overrun_flag <= 1'b1;
            end
            if (rx_store) begin
                rx_full_flag <= 1'b1;
                quiet_armed <= 1'b1;
                rx_holding_reg <= rx_word[7:0];
                if (rx_m) begin
                    rx_ninth_bit <= rx_word[8];
                end
                // noise rises with the full flag
                if (rx_noise) begin
                    noise_flag <= 1'b1;
                end
                if (!maj) begin
                    framing_error_flag <= 1'b1;
                end
                if (par_bad) begin
                    parity_error_flag <= 1'b1;
                end
            end
            if (quiet_set) begin
                quiet_flag <= 1'b1;
                quiet_armed <= 1'b0;
            end
        end
    end

    // interrupt request; receive terms masked while muted
    always_ff @(posedge clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= (ctrl_two[`SPSC_C2_TIE] && tx_empty_flag) ||
                   (ctrl_two[`SPSC_C2_TX_DONE_IRQ_EN] && tx_done_flag) ||
                   (!rx_mute && ctrl_two[`SPSC_C2_RIE] &&
                    (rx_full_flag || overrun_flag)) ||
                   (!rx_mute && ctrl_two[`SPSC_C2_LINE_QUIET_IRQ_EN] && quiet_flag) ||
                   (!rx_mute && ctrl_one[`SPSC_C1_PIE] && parity_error_flag);
        end
    end
endmodule

// ---- tb/spsc_properties.sv ----
// bus and transmit pin checks for the serial port block
`timescale 1ns/1ns
`include "spsc_defines.svh"

module spsc_properties (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // register bus
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // serial pin
    input wire logic txd,
    input wire logic txd_oe
);
    localparam int BT = `SPSC_TICK_DIV * 16;
    int lowrun;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // low time of the pin; only whole bits may appear
    always_ff @(posedge clk) lowrun <= (srst || txd) ? 0 : lowrun + 1;
    sequence s_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    chk_rd_latency: assert property (s_take |=> s_axi_rvalid)
        else $error("read answer late");
    chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
    chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    chk_rdata_upper: assert property (s_axi_rvalid |->
        s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
    chk_unmapped_rd: assert property (s_take ##0 s_axi_araddr == 8'h88
        |=> s_axi_rresp == 2'b10) else $error("unmapped read not refused");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid) else $error("write answer dropped");
    chk_txd_idle: assert property (!txd_oe |-> txd)
        else $error("pin low while not owned");
    chk_bit_time: assert property ($rose(txd) |-> lowrun % BT == 0)
        else $error("low time not whole bits");
endmodule

bind spsc_top spsc_properties u_spsc_properties (
    .clk(clk), .srst(srst), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .txd(txd), .txd_oe(txd_oe));

// ---- tb/spsc_remote.sv ----
// far-side serial transceiver: sends frames, captures the pin
`timescale 1ns/1ns
`include "spsc_defines.svh"

module spsc_remote (
    // clock and request
    input wire logic clk,
    input wire logic go,
    input wire logic [7:0] tx_byte,
    // serial lines
    input wire logic txd,
    output logic line,
    output logic [7:0] got
);
    localparam int BT = `SPSC_TICK_DIV * 16;
    logic [9:0] frame;
    initial line = 1'b1;
    // start low, eight data lsb first, stop high
    always @(posedge go) begin
        frame = {1'b1, tx_byte, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line <= frame[i];
            repeat (BT) @(posedge clk);
        end
    end
    // sample each data bit at its middle
    always @(negedge txd) begin
        repeat (BT / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BT) @(posedge clk);
            got[i] <= txd;
        end
    end
endmodule

// ---- tb/serial_port_status_control_test.sv ----
// self-checking bench for the serial port status and control block
`timescale 1ns/1ns
`include "spsc_defines.svh"

module serial_port_status_control_test;
    localparam int BT = `SPSC_TICK_DIV * 16;
    logic clk = 0, srst = 1, awv = 0, wv = 0, bready = 0, arv = 0;
    logic rready = 0, go = 0, awr, wr, bv, arr, rv, txd, txd_oe, irq, line;
    logic [7:0] awaddr = 0, araddr = 0, tx_byte = 0, q, got;
    logic [31:0] wdata = 0, rdata;
    logic [1:0] bresp, rresp, r;
    int n_fail = 0, checked = 0, cyc = 0;
    spsc_top u_spsc_top (.clk(clk), .srst(srst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rready), .rxd(line), .txd(txd), .txd_oe(txd_oe),
        .irq(irq));
    spsc_remote u_spsc_remote (.clk(clk), .go(go), .tx_byte(tx_byte),
        .txd(txd), .line(line), .got(got));
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            stop_test();
        end
    end
    task automatic acc(input bit w, input logic [7:0] a, input logic [7:0] d);
        if (w) begin
            awaddr <= a;
            wdata <= {24'h0, d};
            awv <= 1;
            wv <= 1;
            bready <= 1;
        end else begin
            araddr <= a;
            arv <= 1;
            rready <= 1;
        end
        do begin
            @(posedge clk);
            if (awv && awr) awv <= 0;
            if (wv && wr) wv <= 0;
            if (arv && arr) arv <= 0;
            if (bready && bv) begin
                bready <= 0;
                r = bresp;
            end
            if (rready && rv) begin
                rready <= 0;
                q = rdata[7:0];
                r = rresp;
            end
        end while (bready || rready);
    endtask
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task automatic send(input logic [7:0] b);
        tx_byte <= b;
        go <= 1;
        @(posedge clk);
        go <= 0;
        repeat (11 * BT) @(posedge clk);
    endtask
    task automatic stop_test();
        $display("checks %0d, failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        srst <= 0;
        @(posedge clk);
        acc(0, 8'h80, 0);
        cmp(q, 8'hC0);
        acc(0, 8'h8C, 0);
        cmp(q, 8'h00);
        acc(0, 8'h90, 0);
        cmp(q, 8'h00);
        // baud place is not mapped, so it must be refused
        acc(0, 8'h88, 0);
        cmp({6'h0, r}, 8'h02);
        acc(1, 8'h90, 8'h08);
        cmp({6'h0, r}, 8'h00);
        cmp({7'h0, txd_oe}, 8'h01);
        acc(0, 8'h80, 0);
        acc(1, 8'h84, 8'hA5);
        // the frame waits for the next tick before it loads
        repeat (30) @(posedge clk);
        acc(0, 8'h80, 0);
        cmp(q & 8'hC0, 8'h80);
        repeat (11 * BT) @(posedge clk);
        acc(0, 8'h80, 0);
        cmp(q & 8'hC0, 8'hC0);
        cmp(got, 8'hA5);
        acc(1, 8'h90, 8'h0C);
        send(8'h3C);
        acc(0, 8'h80, 0);
        cmp(q & 8'h2F, 8'h20);
        // second word lands on a full holding register
        send(8'h5A);
        acc(1, 8'h90, 8'h2C);
        cmp({7'h0, irq}, 8'h01);
        acc(0, 8'h80, 0);
        cmp(q & 8'h2F, 8'h28);
        acc(0, 8'h84, 0);
        cmp(q, 8'h3C);
        acc(0, 8'h80, 0);
        cmp(q & 8'h2F, 8'h00);
        cmp({7'h0, irq}, 8'h00);
        stop_test();
    end
endmodule
